// ### logic/drive_control_word_decoder.sv
// Module: decodes the two cyclic control words into drive command levels and strobes
// Function
// - Bit 10 of word one must be set; otherwise no command bit acts.
// - Bit 0 low requests ramp stop; high lets pulses be enabled.
// - Bit 1 low requests coast stop, pulses removed at once.
// - Bit 2 low requests quick stop along its own ramp.
// - Bit 3 high permits operation; low cancels pulses.
// - Telegrams 1, 3, 102: bit 4 low disables ramp generator.
// - Telegrams 1, 3, 102: bit 5 low freezes ramp generator output.
// - Telegrams 1, 3, 102: bit 6 low zeroes ramp generator input.
// - Bit 7 acknowledges faults; positioning telegram acts on rising edge only.
// - Telegram 105 ignores bits 4, 5 and 6 of word one.
// - Telegrams 102, 105: bit 11 puts ramp generator into effect.
// - Telegrams 102, 105: bit 12 releases holding brake unconditionally.
// - Telegrams 102, 105: bit 14 selects torque, else speed control.
// - Positioning telegram: bit 4 low rejects the current task.
// - Positioning telegram: bit 5 low suspends the running task.
// - Positioning telegram: rising edge of bit 6 starts a task.
// - Positioning telegram: bit 11 high runs homing, low stops it.
// - Telegrams 1, 3, 111: word two bit 8 commands fixed stop travel.
// - Both control words are 16-bit receive words.
`timescale 1ns/100ps
`default_nettype none

module drive_control_word_decoder
	import drive_ctrl_pkg::*;
#(
	parameter int ADDR_WIDTH = 5
) (
	// Clock, reset, enable
	input  wire logic                  clk_sys,
	input  wire logic                  nrst,
	input  wire logic                  ce,
	// AXI4-Lite write address
	input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output var  logic                  s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output var  logic                  s_axi_wready,
	// AXI4-Lite write response
	output var  logic [1:0]            s_axi_bresp,
	output var  logic                  s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output var  logic                  s_axi_arready,
	// AXI4-Lite read data
	output var  logic [31:0]           s_axi_rdata,
	output var  logic [1:0]            s_axi_rresp,
	output var  logic                  s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// Stop and pulse commands
	output var  logic                  host_control,
	output var  logic                  ramp_stop,
	output var  logic                  coast_stop,
	output var  logic                  quick_stop,
	output var  logic                  run_enable,
	output var  logic                  pulse_enable,
	// Ramp generator and loop commands
	output var  logic                  rfg_enable,
	output var  logic                  rfg_continue,
	output var  logic                  setpoint_enable,
	output var  logic                  rfg_in_effect,
	output var  logic                  brake_release,
	output var  logic                  torque_mode,
	output var  logic                  fault_ack,
	// Positioning commands
	output var  logic                  task_reject,
	output var  logic                  task_suspend,
	output var  logic                  task_start,
	output var  logic                  jog_mode_one,
	output var  logic                  jog_mode_two,
	output var  logic                  homing,
	output var  logic                  fixed_stop,
	output var  logic [3:0]            life_count
);

	// Decode needs the five low address bits; wider buses only flag out-of-map accesses
	if (ADDR_WIDTH < 5 || ADDR_WIDTH > 32) begin : g_bad_width
		$error("ADDR_WIDTH must lie between 5 and 32");
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic telegram_class_type classify(input logic [7:0] code);
		telegram_class_type c;
		case (code)
			TG_ONE, TG_THREE: c = CLASS_STD;
			TG_SPEED:         c = CLASS_SPEED;
			TG_DSC:           c = CLASS_DSC;
			TG_POS:           c = CLASS_POS;
			default:          c = CLASS_NONE;
		endcase
		return c;
	endfunction : classify

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
						input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0])
			r[7:0] = data[7:0];
		if (strb[1])
			r[15:8] = data[15:8];
		return r;
	endfunction : merge16

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [15:0]         control_word_one;
	logic [15:0]         control_word_two;
	logic [7:0]          telegram;
	logic [15:0]         prev_word_one;
	logic [4:0]          aw_addr;
	logic [31:0]         w_data;
	logic [3:0]          w_strb;
	telegram_class_type  tclass;
	logic [31:0]         status_word;
	logic                write_go;

	assign tclass   = classify(telegram);
	assign write_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	// ----------------------------------------
	// Write channels
	// ----------------------------------------
	// Address and data are taken in either order; the response waits for both.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_addr       <= 5'h00;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				// Out-of-map addresses fold onto an unmapped slot, never onto a register
				aw_addr       <= (s_axi_awaddr > 31) ? 5'h1f : s_axi_awaddr[4:0];
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (write_go) begin
				s_axi_bvalid <= 1'b1;
				if (aw_addr == ADDR_CW_ONE || aw_addr == ADDR_CW_TWO || aw_addr == ADDR_TELEGRAM)
					s_axi_bresp <= RESP_OKAY;
				else
					s_axi_bresp <= RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Control words hold 16 bits; upper lanes are dropped
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			control_word_one <= CW_RESET;
			control_word_two <= CW_RESET;
			telegram         <= TELEGRAM_RESET;
		end else if (ce && write_go) begin
			if (aw_addr == ADDR_CW_ONE)
				control_word_one <= merge16(control_word_one, w_data, w_strb);
			if (aw_addr == ADDR_CW_TWO)
				control_word_two <= merge16(control_word_two, w_data, w_strb);
			if (aw_addr == ADDR_TELEGRAM && w_strb[0])
				telegram <= w_data[7:0];
		end
	end

	// Previous word one, for the edge-triggered positioning bits
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			prev_word_one <= CW_RESET;
		else if (ce)
			prev_word_one <= control_word_one;
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	assign status_word = {8'h00, life_count, fixed_stop, homing, jog_mode_two, jog_mode_one,
			      task_start, task_suspend, task_reject, fault_ack, torque_mode, brake_release,
			      rfg_in_effect, setpoint_enable, rfg_continue, rfg_enable, pulse_enable,
			      run_enable, quick_stop, coast_stop, ramp_stop, host_control};

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= RESP_OKAY;
				case (s_axi_araddr[4:0])
					ADDR_CW_ONE:   s_axi_rdata <= {16'h0000, control_word_one};
					ADDR_CW_TWO:   s_axi_rdata <= {16'h0000, control_word_two};
					ADDR_TELEGRAM: s_axi_rdata <= {24'h000000, telegram};
					ADDR_STATUS:   s_axi_rdata <= status_word;
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
				if (s_axi_araddr[ADDR_WIDTH-1:2] > 3) begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	logic       next_control;
	logic       next_ramp_stop;
	logic       next_coast_stop;
	logic       next_quick_stop;
	logic       next_run_enable;
	logic       next_pulse_enable;
	logic       next_rfg_enable;
	logic       next_rfg_continue;
	logic       next_setpoint_enable;
	logic       next_rfg_in_effect;
	logic       next_brake_release;
	logic       next_torque_mode;
	logic       next_fault_ack;
	logic       next_task_reject;
	logic       next_task_suspend;
	logic       next_task_start;
	logic       next_jog_one;
	logic       next_jog_two;
	logic       next_homing;
	logic       next_fixed_stop;
	logic [3:0] next_life_count;
	logic [15:0] rise;

	// Only bits named below are read; every other bit has no effect
	always_comb begin
		rise                 = control_word_one & ~prev_word_one;
		next_control         = control_word_one[B1_CONTROL] && tclass != CLASS_NONE;
		next_ramp_stop       = 1'b0;
		next_coast_stop      = 1'b0;
		next_quick_stop      = 1'b0;
		next_run_enable      = 1'b0;
		next_pulse_enable    = 1'b0;
		next_rfg_enable      = 1'b0;
		next_rfg_continue    = 1'b0;
		next_setpoint_enable = 1'b0;
		next_rfg_in_effect   = 1'b0;
		next_brake_release   = 1'b0;
		next_torque_mode     = 1'b0;
		next_fault_ack       = 1'b0;
		next_task_reject     = 1'b0;
		next_task_suspend    = 1'b0;
		next_task_start      = 1'b0;
		next_jog_one         = 1'b0;
		next_jog_two         = 1'b0;
		next_homing          = 1'b0;
		next_fixed_stop      = 1'b0;
		// Count passes even without control so the drive can watch a stalled host
		next_life_count      = (telegram == TG_ONE) ? 4'h0 : control_word_two[B2_LIFE_LSB +: 4];
		if (next_control) begin
			// Coast stop outranks quick stop, which outranks ramp stop
			next_coast_stop   = !control_word_one[B1_NO_COAST];
			next_quick_stop   = control_word_one[B1_NO_COAST] && !control_word_one[B1_NO_QUICK];
			next_ramp_stop    = control_word_one[B1_NO_COAST] && control_word_one[B1_NO_QUICK]
					    && !control_word_one[B1_ON];
			next_run_enable   = control_word_one[B1_RUN];
			next_pulse_enable = control_word_one[B1_ON] && control_word_one[B1_NO_COAST]
					    && control_word_one[B1_NO_QUICK] && control_word_one[B1_RUN];
			case (tclass)
				CLASS_STD, CLASS_SPEED: begin
					next_rfg_enable      = control_word_one[B1_RFG_EN];
					next_rfg_continue    = control_word_one[B1_RFG_RUN];
					next_setpoint_enable = control_word_one[B1_SETPOINT];
					next_fault_ack       = control_word_one[B1_FAULT_ACK];
				end
				CLASS_DSC: begin
					// Bits 4 to 6 are ignored: the ramp generator is left unrestricted
					next_rfg_enable      = 1'b1;
					next_rfg_continue    = 1'b1;
					next_setpoint_enable = 1'b1;
					next_fault_ack       = control_word_one[B1_FAULT_ACK];
				end
				CLASS_POS: begin
					next_task_reject  = !control_word_one[B1_RFG_EN];
					next_task_suspend = !control_word_one[B1_RFG_RUN];
					next_task_start   = rise[B1_SETPOINT];
					next_fault_ack    = rise[B1_FAULT_ACK];
					next_jog_one      = control_word_one[B1_JOG_ONE];
					next_jog_two      = control_word_one[B1_JOG_TWO];
					next_homing       = control_word_one[B1_BIT11];
				end
				default: begin
					next_fault_ack = 1'b0;
				end
			endcase
			if (tclass == CLASS_SPEED || tclass == CLASS_DSC) begin
				next_rfg_in_effect = control_word_one[B1_BIT11];
				next_brake_release = control_word_one[B1_BRAKE];
				next_torque_mode   = control_word_one[B1_TORQUE];
			end
			if (tclass == CLASS_STD || tclass == CLASS_POS)
				next_fixed_stop = control_word_two[B2_FIXED_STOP];
		end
	end

	// ----------------------------------------
	// Command outputs
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			host_control    <= 1'b0;
			ramp_stop       <= 1'b0;
			coast_stop      <= 1'b0;
			quick_stop      <= 1'b0;
			run_enable      <= 1'b0;
			pulse_enable    <= 1'b0;
			rfg_enable      <= 1'b0;
			rfg_continue    <= 1'b0;
			setpoint_enable <= 1'b0;
			rfg_in_effect   <= 1'b0;
			brake_release   <= 1'b0;
			torque_mode     <= 1'b0;
			fault_ack       <= 1'b0;
			task_reject     <= 1'b0;
			task_suspend    <= 1'b0;
			task_start      <= 1'b0;
			jog_mode_one    <= 1'b0;
			jog_mode_two    <= 1'b0;
			homing          <= 1'b0;
			fixed_stop      <= 1'b0;
			life_count      <= 4'h0;
		end else if (ce) begin
			host_control    <= next_control;
			ramp_stop       <= next_ramp_stop;
			coast_stop      <= next_coast_stop;
			quick_stop      <= next_quick_stop;
			run_enable      <= next_run_enable;
			pulse_enable    <= next_pulse_enable;
			rfg_enable      <= next_rfg_enable;
			rfg_continue    <= next_rfg_continue;
			setpoint_enable <= next_setpoint_enable;
			rfg_in_effect   <= next_rfg_in_effect;
			brake_release   <= next_brake_release;
			torque_mode     <= next_torque_mode;
			fault_ack       <= next_fault_ack;
			task_reject     <= next_task_reject;
			task_suspend    <= next_task_suspend;
			task_start      <= next_task_start;
			jog_mode_one    <= next_jog_one;
			jog_mode_two    <= next_jog_two;
			homing          <= next_homing;
			fixed_stop      <= next_fixed_stop;
			life_count      <= next_life_count;
		end
	end

endmodule : drive_control_word_decoder

`default_nettype wire

// ### logic/drive_ctrl_pkg.sv
// Package: register map, bit positions and telegram codes of the control word decoder
`default_nettype none

package drive_ctrl_pkg;

	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [4:0] ADDR_CW_ONE    = 5'h00;
	localparam logic [4:0] ADDR_CW_TWO    = 5'h04;
	localparam logic [4:0] ADDR_TELEGRAM  = 5'h08;
	localparam logic [4:0] ADDR_STATUS    = 5'h0c;

	// ----------------------------------------
	// Values after reset
	// ----------------------------------------
	localparam logic [15:0] CW_RESET       = 16'h0000;
	localparam logic [7:0]  TELEGRAM_RESET = 8'h01;

	// ----------------------------------------
	// Telegram codes
	// ----------------------------------------
	localparam logic [7:0] TG_ONE   = 8'h01;
	localparam logic [7:0] TG_THREE = 8'h03;
	localparam logic [7:0] TG_SPEED = 8'h66;
	localparam logic [7:0] TG_DSC   = 8'h69;
	localparam logic [7:0] TG_POS   = 8'h6f;

	// ----------------------------------------
	// Bit positions in control_word_one
	// ----------------------------------------
	localparam int B1_ON        = 0;
	localparam int B1_NO_COAST  = 1;
	localparam int B1_NO_QUICK  = 2;
	localparam int B1_RUN       = 3;
	localparam int B1_RFG_EN    = 4;
	localparam int B1_RFG_RUN   = 5;
	localparam int B1_SETPOINT  = 6;
	localparam int B1_FAULT_ACK = 7;
	localparam int B1_JOG_ONE   = 8;
	localparam int B1_JOG_TWO   = 9;
	localparam int B1_CONTROL   = 10;
	localparam int B1_BIT11     = 11;
	localparam int B1_BRAKE     = 12;
	localparam int B1_TORQUE    = 14;

	// ----------------------------------------
	// Bit positions in control_word_two
	// ----------------------------------------
	localparam int B2_FIXED_STOP = 8;
	localparam int B2_LIFE_LSB   = 12;

	// ----------------------------------------
	// Bus responses
	// ----------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		CLASS_NONE,
		CLASS_STD,
		CLASS_SPEED,
		CLASS_DSC,
		CLASS_POS
	} telegram_class_type;

endpackage : drive_ctrl_pkg

`default_nettype wire

// ### sim/drive_control_word_decoder_test.sv
// Testbench: control word decoder driven by the host model
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin err_count++; \
	$display("Error %s: expected %h seen %h", n, e, s); end end

module drive_control_word_decoder_test;
	import drive_ctrl_pkg::*;
	logic clk_sys = 0, nrst = 0, ce = 1;
	logic [4:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d1, d2, ep;
	logic [3:0] s_axi_wstrb, life_count;
	logic [1:0] s_axi_bresp, s_axi_rresp, eb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic host_control, ramp_stop, coast_stop, quick_stop, run_enable, pulse_enable, rfg_enable;
	logic rfg_continue, setpoint_enable, rfg_in_effect, brake_release, torque_mode, fault_ack;
	logic task_reject, task_suspend, task_start, jog_mode_one, jog_mode_two, homing, fixed_stop;
	logic [33:0] er, rq[$];
	logic [1:0] bq[$];
	logic [7:0] tgs[6] = '{TG_ONE, TG_THREE, TG_SPEED, TG_DSC, TG_POS, 8'h22};
	int err_count = 0, num_checks = 0, ts_n = 0, fa_n = 0;

	always #20 clk_sys = ~clk_sys;

	drive_control_word_decoder #(.ADDR_WIDTH(5)) uut (.clk_sys, .nrst, .ce, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .host_control, .ramp_stop, .coast_stop, .quick_stop, .run_enable,
		.pulse_enable, .rfg_enable, .rfg_continue, .setpoint_enable, .rfg_in_effect, .brake_release,
		.torque_mode, .fault_ack, .task_reject, .task_suspend, .task_start, .jog_mode_one, .jog_mode_two,
		.homing, .fixed_stop, .life_count);

	host_plc host (.clk_sys, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid,
		.s_axi_awaddr, .s_axi_araddr, .s_axi_wdata, .s_axi_wstrb, .s_axi_awvalid, .s_axi_wvalid,
		.s_axi_bready, .s_axi_arvalid, .s_axi_rready);

	// ----------------------------------------
	// Expected status word
	// ----------------------------------------
	function automatic logic [31:0] exp_st(logic [15:0] w, logic [15:0] v, logic [7:0] t);
		logic c, p, s, r, n;
		logic [31:0] e;
		c = (t inside {TG_ONE, TG_THREE, TG_SPEED, TG_DSC, TG_POS}) && w[10];
		p = t == TG_POS;
		s = t inside {TG_SPEED, TG_DSC};
		r = t inside {TG_ONE, TG_THREE, TG_SPEED};
		n = t == TG_DSC;
		e = '0;
		e[0] = c;
		e[2] = c & !w[1];
		e[3] = c & w[1] & !w[2];
		e[1] = c & w[1] & w[2] & !w[0];
		e[4] = c & w[3];
		e[5] = c & (&w[3:0]);
		e[6] = c & (n | r & w[4]);
		e[7] = c & (n | r & w[5]);
		e[8] = c & (n | r & w[6]);
		e[9] = c & s & w[11];
		e[10] = c & s & w[12];
		e[11] = c & s & w[14];
		e[12] = c & !p & w[7];
		e[13] = c & p & !w[4];
		e[14] = c & p & !w[5];
		e[16] = c & p & w[8];
		e[17] = c & p & w[9];
		e[18] = c & p & w[11];
		e[19] = c & !s & v[8];
		e[23:20] = (t == TG_ONE) ? 4'h0 : v[15:12];
		return e;
	endfunction : exp_st

	task automatic wq(input logic [4:0] a, input logic [31:0] d, input logic [1:0] b, input logic [3:0] s = 4'hf);
		bq.push_back(b);
		host.wr(a, d, s);
	endtask : wq

	task automatic rdq(input logic [4:0] a, input logic [33:0] e);
		rq.push_back(e);
		host.rd(a);
	endtask : rdq

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	// ----------------------------------------
	// Result watcher
	// ----------------------------------------
	always @(posedge clk_sys) begin
		ts_n += task_start;
		fa_n += fault_ack;
		if (s_axi_bvalid && s_axi_bready) begin
			eb = bq.pop_front();
			`CHK("bresp", eb, s_axi_bresp)
		end
		if (s_axi_rvalid && s_axi_rready) begin
			er = rq.pop_front();
			`CHK("read", er, {s_axi_rresp, s_axi_rdata})
		end
	end

	initial begin
		#400us;
		err_count++;
		wrap_up();
	end

	initial begin
		void'($urandom(78));
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		rdq(ADDR_CW_ONE, {RESP_OKAY, 32'h0});
		rdq(ADDR_CW_TWO, {RESP_OKAY, 32'h0});
		rdq(ADDR_TELEGRAM, {RESP_OKAY, 24'h0, TELEGRAM_RESET});
		rdq(ADDR_STATUS, {RESP_OKAY, 32'h0});
		$display("reset test done");
		// Random words under every telegram; unknown code drops all commands
		foreach (tgs[i]) begin
			wq(ADDR_TELEGRAM, {24'h0, tgs[i]}, RESP_OKAY);
			rdq(ADDR_TELEGRAM, {RESP_OKAY, 24'h0, tgs[i]});
			repeat (6) begin
				d1 = $urandom;
				d2 = $urandom;
				if (i == 5)
					d2[15:12] = 4'h0;
				wq(ADDR_CW_ONE, d1, RESP_OKAY);
				wq(ADDR_CW_TWO, d2, RESP_OKAY);
				rdq(ADDR_CW_ONE, {RESP_OKAY, 16'h0, d1[15:0]});
				rdq(ADDR_STATUS, {RESP_OKAY, exp_st(d1[15:0], d2[15:0], tgs[i])});
				// The command pins themselves, in status word order
				ep = {8'h00, life_count, fixed_stop, homing, jog_mode_two, jog_mode_one, task_start,
				      task_suspend, task_reject, fault_ack, torque_mode, brake_release, rfg_in_effect,
				      setpoint_enable, rfg_continue, rfg_enable, pulse_enable, run_enable, quick_stop,
				      coast_stop, ramp_stop, host_control};
				`CHK("command ports", exp_st(d1[15:0], d2[15:0], tgs[i]), ep)
			end
		end
		$display("telegram test done");
		// Edge-started task and fault acknowledge pulse once per rising edge
		wq(ADDR_TELEGRAM, {24'h0, TG_POS}, RESP_OKAY);
		wq(ADDR_CW_ONE, 32'h0400, RESP_OKAY);
		ts_n = 0;
		fa_n = 0;
		wq(ADDR_CW_ONE, 32'h04c0, RESP_OKAY);
		// Clock enable low holds the pulses: one cycle plus three frozen ones
		ce <= 1'b0;
		repeat (3) @(posedge clk_sys);
		ce <= 1'b1;
		wq(ADDR_CW_ONE, 32'h04c0, RESP_OKAY);
		repeat (3) @(posedge clk_sys);
		`CHK("task_start pulses", 4, ts_n)
		`CHK("fault_ack pulses", 4, fa_n)
		$display("edge test done");
		// Read-only and unmapped places are refused
		wq(ADDR_STATUS, 32'hffff, RESP_SLVERR);
		wq(5'h10, 32'h1234, RESP_SLVERR);
		rdq(5'h10, {RESP_SLVERR, 32'h0});
		// Byte strobes write one lane of a word at a time
		wq(ADDR_CW_ONE, 32'hab3f, RESP_OKAY, 4'h1);
		wq(ADDR_CW_ONE, 32'h12ff, RESP_OKAY, 4'h2);
		rdq(ADDR_CW_ONE, {RESP_OKAY, 16'h0, 16'h123f});
		repeat (2) @(posedge clk_sys);
		`CHK("pending", 0, rq.size() + bq.size())
		$display("refusal test done");
		wrap_up();
	end
endmodule : drive_control_word_decoder_test

`default_nettype wire

// ### sim/drive_ctrl_chk.sv
// Checker: port-level properties of the control word decoder
`timescale 1ns/100ps
`default_nettype none

module drive_ctrl_chk (
	// Clock and reset
	input wire logic        clk_sys, nrst, ce,
	// Bus handshakes
	input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
	input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
	input wire logic        s_axi_rvalid, s_axi_rready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic [31:0] s_axi_rdata,
	// Commands
	input wire logic        host_control, ramp_stop, coast_stop, quick_stop, run_enable, pulse_enable,
	input wire logic        rfg_in_effect, brake_release, torque_mode, task_start,
	input wire logic        jog_mode_one, jog_mode_two, homing
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	// ----------------------------------------
	// Bus timing
	// ----------------------------------------
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid)
		else $error("write answer late");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");

	// ----------------------------------------
	// Command relations
	// ----------------------------------------
	no_control_a: assert property (!host_control |-> !(pulse_enable || run_enable || ramp_stop
		|| coast_stop || quick_stop || brake_release || torque_mode || jog_mode_one || homing))
		else $error("command without host control");
	pulse_gate_a: assert property (pulse_enable |-> run_enable && !ramp_stop
		&& !coast_stop && !quick_stop)
		else $error("pulses enabled during a stop");
	coast_first_a: assert property (coast_stop |-> !quick_stop && !ramp_stop)
		else $error("coast stop not dominant");
	start_pulse_a: assert property (task_start && ce |=> !task_start)
		else $error("task start longer than one cycle");
	tg_split_a: assert property (jog_mode_one || jog_mode_two || homing || task_start
		|-> !(rfg_in_effect || brake_release || torque_mode))
		else $error("positioning and speed commands mixed");

	cover property (task_start);
	cover property (brake_release && torque_mode);
	cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
	cover property (pulse_enable);
endmodule : drive_ctrl_chk

bind drive_control_word_decoder drive_ctrl_chk chk (.clk_sys, .nrst, .ce, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_rdata, .host_control, .ramp_stop, .coast_stop,
	.quick_stop, .run_enable, .pulse_enable, .rfg_in_effect, .brake_release, .torque_mode, .task_start,
	.jog_mode_one, .jog_mode_two, .homing);

`default_nettype wire

// ### sim/host_plc.sv
// Partner: host controller that sends control words over the register bus
`timescale 1ns/100ps
`default_nettype none

module host_plc (
	// Clock
	input  wire logic        clk_sys,
	// Answers from the drive
	input  wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
	// Requests to the drive
	output var  logic [4:0]  s_axi_awaddr, s_axi_araddr,
	output var  logic [31:0] s_axi_wdata,
	output var  logic [3:0]  s_axi_wstrb,
	output var  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
	end

	// All four byte strobes by default; a caller may pass a narrower strobe to write one lane only
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
		logic ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && dd)) begin
			@(posedge clk_sys);
			if (s_axi_awvalid && s_axi_awready) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				dd = 1'b1;
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end
		do @(posedge clk_sys); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [4:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk_sys); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~a;
		do @(posedge clk_sys); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : rd
endmodule : host_plc

`default_nettype wire
